// ### design/temp_result_format.sv
/*
  Combinational formatter: signed raw temperature in eighths of a degree
  to a high byte (whole degrees) and low byte (eighths), with clamping
  in binary and offset-binary form and the diode fault code.
  Assumes the raw value and fault flag come from same-clock logic.
*/
`timescale 1ns/1ps
module temp_result_format (
  input  wire logic signed [temp_scan_pkg::RAW_W-1:0] rawTemp,
  input  wire logic                                   fault,
  input  wire logic                                   extRange,
  output logic [7:0]                                  hiByte,
  output logic [7:0]                                  loByte
);
  import temp_scan_pkg::*;

  logic signed [DEG_W-1:0] wholeDeg;
  logic [7:0]              fracByte;

  // Upper bits of two's complement give floor of the degree count
  assign wholeDeg = rawTemp[RAW_W-1:FRAC_W];
  assign fracByte = {5'h00, rawTemp[FRAC_W-1:0]};

  always_comb begin
    hiByte = wholeDeg[7:0];
    loByte = fracByte;
    if (fault) begin
      hiByte = FAULT_CODE;
      loByte = FAULT_CODE;
    end else if (extRange) begin
      if (wholeDeg <= EXT_MIN_DEG) begin
        hiByte = OFS_LOW_CLAMP;
        loByte = 8'h00;
      end else if (wholeDeg >= EXT_MAX_DEG) begin
        hiByte = OFS_HIGH_CLAMP;
        loByte = 8'h00;
      end else begin
        hiByte = wholeDeg[7:0] + OFFSET_CODE;
      end
    end else if (wholeDeg < 0) begin
      hiByte = 8'h00;
      loByte = 8'h00;
    end else if (wholeDeg > BIN_MAX_DEG) begin
      hiByte = BIN_HIGH_CLAMP;
      loByte = 8'h00;
    end
  end

endmodule // temp_result_format

// ### design/temp_scan_alarm_format.sv
/*
  Sensor scan sequencer, excitation port control, result store, two
  hysteresis alarms and an APB register slave.
  Assumes a digital converter on sys_clk that takes adcStart/adcSel and
  answers with adcDone plus a signed raw result and saturation flags.
*/
// Behaviour
// - Scan up to four enabled sensors automatically.
// - Order internal, ext1, ext2, ext3, skip disabled.
// - Store result in converted sensor's register pair.
// - Thresholds use the selected result format.
// - Alarms evaluated only when a conversion ends.
// - Each alarm picks any sensor as source.
// - Trip above threshold, or below if under.
// - Per-alarm active level and direction configurable.
// - Over alarm holds until at/below threshold-hysteresis.
// - High byte whole degrees, low byte eighths.
// - Binary default; extended adds 64 to code.
// - Binary clamps below zero to zero.
// - Binary clamps above 127 to 7F.
// - Offset binary saturates at 18 and CC.
// - High and low bytes update together.
// - Three-point: anode excitation, cathode cancellation current.
// - Three-point: equal currents, differential sense.
// - Four-wire: force ports three/four, sense one/two.
// - Converter saturation gives all-ones in both bytes.
// - Single mode: one pass, then standby.
`timescale 1ns/1ps
module temp_scan_alarm_format (
  input  wire logic                                   sys_clk,
  input  wire logic                                   srst,
  input  wire logic [7:0]                             paddr,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [31:0]                            pwdata,
  output logic                                        pready,
  output logic [31:0]                                 prdata,
  output logic                                        pslverr,
  output logic                                        adcStart,
  output logic [1:0]                                  adcSel,
  input  wire logic                                   adcDone,
  input  wire logic signed [temp_scan_pkg::RAW_W-1:0] adcTemp,
  input  wire logic                                   adcSatLow,
  input  wire logic                                   adcSatHigh,
  output logic [3:0]                                  portExcite,
  output logic [3:0]                                  portCancel,
  output logic                                        currentMatch,
  output logic                                        senseDiff,
  output logic [1:0]                                  sensePos,
  output logic [1:0]                                  senseNeg,
  output logic                                        firstAlarmOutput,
  output logic                                        secondAlarmOutput
);
  import temp_scan_pkg::*;

  typedef struct packed {
    logic [3:0]         scanSel;
    logic [7:0]         thrA;
    logic [7:0]         thrB;
    logic [7:0]         alarmCfg;
    logic [7:0]         hyst;
    logic               extRange;
    logic               contMode;
    cancel_mode_t       cancelMode;
    logic               startReq;
    logic [3:0][7:0]    resHi;
    logic [3:0][7:0]    resLo;
    scan_state_t        state;
    logic [1:0]         cur;
    logic [1:0]         alarmAct;
    logic [1:0]         alarmOut;
    logic               adcStart;
    logic [1:0]         adcSel;
    logic [DRIVE_W-1:0] drive;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
  } state_t;

  state_t                  s;
  state_t                  next_s;
  logic [7:0]              fmtHi;
  logic [7:0]              fmtLo;
  logic                    adcFault;
  logic signed [DEG_W-1:0] wholeDeg;
  logic [1:0]              nxtSensor;
  logic [1:0]              firstSensor;
  logic                    passEnd;
  logic                    doLaunch;
  logic [1:0]              launchSel;
  logic                    apbAccess;

  // Hysteresis compare on the formatted code, widened against overflow
  function automatic logic alarmNext(input logic       act,
                                     input logic [7:0] code,
                                     input logic [7:0] thr,
                                     input logic [7:0] hy,
                                     input logic       under);
    logic signed [9:0] c;
    logic signed [9:0] t;
    logic signed [9:0] h;
    c = signed'({2'b00, code});
    t = signed'({2'b00, thr});
    h = signed'({2'b00, hy});
    if (under) begin
      alarmNext = act ? (c < t + h) : (c < t);
    end else begin
      alarmNext = act ? (c > t - h) : (c > t);
    end
  endfunction

  // {excite, cancel, match, diff, pos, neg}
  function automatic logic [DRIVE_W-1:0] portDrive(
      input logic [1:0] sensor, input cancel_mode_t mode);
    logic [1:0] pin;
    portDrive = '0;
    pin       = sensor - 2'd1;
    if (sensor != 2'd0) begin
      case (mode)
        CANCEL_THREE_POINT: begin
          portDrive = {4'h1, 4'h2, 1'b1, 1'b1, 2'd0, 2'd1};
        end
        CANCEL_FOUR_WIRE: begin
          portDrive = {4'hC, 4'h0, 1'b0, 1'b1, 2'd0, 2'd1};
        end
        default: begin
          portDrive = {4'h1 << pin, 4'h0, 1'b0, 1'b0, pin, 2'd0};
        end
      endcase
    end
  endfunction

  temp_result_format u_fmt (
    .rawTemp  (adcTemp),
    .fault    (adcFault),
    .extRange (s.extRange),
    .hiByte   (fmtHi),
    .loByte   (fmtLo)
  );

  assign adcFault    = adcSatLow || adcSatHigh;
  assign wholeDeg    = adcTemp[RAW_W-1:FRAC_W];
  assign nxtSensor   = nextSensor(s.cur, s.scanSel);
  assign firstSensor = nextSensor(2'd3, s.scanSel);
  assign passEnd     = (nxtSensor <= s.cur);
  assign apbAccess   = psel && penable && !s.pready;

  always_comb begin
    next_s          = s;
    next_s.adcStart = 1'b0;
    next_s.pready   = 1'b0;
    next_s.pslverr  = 1'b0;
    doLaunch        = 1'b0;
    launchSel       = firstSensor;
    case (s.state)
      ST_IDLE: begin
        if ((s.startReq || s.contMode) && s.scanSel != 4'h0) begin
          doLaunch = 1'b1;
        end
        next_s.startReq = 1'b0;
      end
      ST_WAIT: begin
        if (adcDone) begin
          next_s.resHi[s.cur] = fmtHi;
          next_s.resLo[s.cur] = fmtLo;
          for (int k = 0; k < 2; k++) begin
            // Faulty readings leave the alarm where it was
            if (!adcFault &&
                s.alarmCfg[ALM_W*k+ALM_SRC_LSB +: 2] == s.cur) begin
              next_s.alarmAct[k] = alarmNext(s.alarmAct[k], fmtHi,
                                             (k == 0) ? s.thrA : s.thrB,
                                             s.hyst,
                                             s.alarmCfg[ALM_W*k+ALM_UNDER_BIT]);
            end
          end
          next_s.state = ST_STORE;
        end
      end
      ST_STORE: begin
        if (s.scanSel != 4'h0 && (!passEnd || s.contMode)) begin
          doLaunch  = 1'b1;
          launchSel = nxtSensor;
        end else begin
          next_s.state = ST_IDLE;
          next_s.drive = '0;
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase
    if (doLaunch) begin
      next_s.cur      = launchSel;
      next_s.adcSel   = launchSel;
      next_s.adcStart = 1'b1;
      next_s.state    = ST_WAIT;
      next_s.drive    = portDrive(launchSel, s.cancelMode);
    end
    for (int k = 0; k < 2; k++) begin
      next_s.alarmOut[k] =
        (s.alarmCfg[ALM_W*k+ALM_POL_BIT] == s.alarmAct[k]);
    end
    // Register writes come last so a start request beats the clear
    if (apbAccess) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (paddr[1:0] != 2'b00) begin
        next_s.pslverr = 1'b1;
      end else if (pwrite) begin
        case (paddr)
          OFS_SCAN:    next_s.scanSel  = pwdata[3:0];
          OFS_THR_A:   next_s.thrA     = pwdata[7:0];
          OFS_THR_B:   next_s.thrB     = pwdata[7:0];
          OFS_ALM_CFG: next_s.alarmCfg = pwdata[7:0];
          OFS_HYST:    next_s.hyst     = pwdata[7:0];
          OFS_CTRL: begin
            next_s.extRange   = pwdata[CTRL_EXT_BIT];
            next_s.contMode   = pwdata[CTRL_CONT_BIT];
            next_s.cancelMode =
              cancel_mode_t'(pwdata[CTRL_CANCEL_LSB +: 2]);
            if (pwdata[CTRL_START_BIT]) begin
              next_s.startReq = 1'b1;
            end
          end
          OFS_STATUS: begin
          end
          default: begin
            if (paddr < OFS_RESULT || paddr > OFS_RESULT_END) begin
              next_s.pslverr = 1'b1;
            end
          end
        endcase
      end else begin
        case (paddr)
          OFS_SCAN:    next_s.prdata = {28'h0, s.scanSel};
          OFS_THR_A:   next_s.prdata = {24'h0, s.thrA};
          OFS_THR_B:   next_s.prdata = {24'h0, s.thrB};
          OFS_ALM_CFG: next_s.prdata = {24'h0, s.alarmCfg};
          OFS_HYST:    next_s.prdata = {24'h0, s.hyst};
          OFS_CTRL: begin
            next_s.prdata = {27'h0, s.cancelMode, 1'b0,
                             s.contMode, s.extRange};
          end
          OFS_STATUS: begin
            next_s.prdata = {27'h0, s.alarmAct, s.cur,
                             s.state != ST_IDLE};
          end
          default: begin
            if (paddr < OFS_RESULT || paddr > OFS_RESULT_END) begin
              next_s.pslverr = 1'b1;
            end else if (paddr[2]) begin
              next_s.prdata = {24'h0, s.resLo[paddr[4:3]]};
            end else begin
              next_s.prdata = {24'h0, s.resHi[paddr[4:3]]};
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s          <= '0;
      s.scanSel  <= RST_SCAN;
      s.thrA     <= RST_THR_A;
      s.thrB     <= RST_THR_B;
      s.alarmCfg <= RST_ALM_CFG;
      s.hyst     <= RST_HYST;
      s.alarmOut <= 2'b11;
    end else begin
      s <= next_s;
    end
  end

  assign pready            = s.pready;
  assign prdata            = s.prdata;
  assign pslverr           = s.pslverr;
  assign adcStart          = s.adcStart;
  assign adcSel            = s.adcSel;
  assign portExcite        = s.drive[13:10];
  assign portCancel        = s.drive[9:6];
  assign currentMatch      = s.drive[5];
  assign senseDiff         = s.drive[4];
  assign sensePos          = s.drive[3:2];
  assign senseNeg          = s.drive[1:0];
  assign firstAlarmOutput  = s.alarmOut[0];
  assign secondAlarmOutput = s.alarmOut[1];

  sequence s_conv_done;
    s.state == ST_WAIT && adcDone;
  endsequence

  sequence s_store_more;
    s.state == ST_STORE && !passEnd && s.scanSel != 4'h0;
  endsequence

  property p_start_enabled;
    @(posedge sys_clk) disable iff (srst)
    adcStart |-> (($past(s.scanSel) >> adcSel) & 4'h1) != 4'h0;
  endproperty
  a_start_enabled: assert property (p_start_enabled)
    else $error("conversion started on a disabled sensor");

  property p_next_order;
    @(posedge sys_clk) disable iff (srst)
    s_store_more |=> adcStart && adcSel == $past(nxtSensor);
  endproperty
  a_next_order: assert property (p_next_order)
    else $error("scan did not move to next enabled sensor");

  property p_store_pair;
    @(posedge sys_clk) disable iff (srst)
    s_conv_done |=> s.resHi[$past(s.cur)] == $past(fmtHi) &&
                    s.resLo[$past(s.cur)] == $past(fmtLo);
  endproperty
  a_store_pair: assert property (p_store_pair)
    else $error("result pair not stored for converted sensor");

  property p_fault_code;
    @(posedge sys_clk) disable iff (srst)
    s_conv_done ##0 adcFault |=>
      s.resHi[$past(s.cur)] == FAULT_CODE &&
      s.resLo[$past(s.cur)] == FAULT_CODE;
  endproperty
  a_fault_code: assert property (p_fault_code)
    else $error("diode fault not reported as all ones");

  property p_single_stop;
    @(posedge sys_clk) disable iff (srst)
    (s.state == ST_STORE && passEnd && !s.contMode) |=>
      s.state == ST_IDLE && !adcStart;
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single pass did not return to standby");

  property p_alarm_hold;
    @(posedge sys_clk) disable iff (srst)
    !(s.state == ST_WAIT && adcDone) |=> $stable(s.alarmAct);
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm changed without a finished conversion");

  property p_over_trip;
    @(posedge sys_clk) disable iff (srst)
    s_conv_done ##0 (!adcFault && !s.alarmAct[0] &&
      s.alarmCfg[ALM_SRC_LSB +: 2] == s.cur &&
      !s.alarmCfg[ALM_UNDER_BIT] && fmtHi > s.thrA) |=> s.alarmAct[0];
  endproperty
  a_over_trip: assert property (p_over_trip)
    else $error("over temperature did not trip first alarm");

  property p_polarity;
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> firstAlarmOutput ==
      ($past(s.alarmCfg[ALM_POL_BIT]) == $past(s.alarmAct[0]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("first alarm level does not follow polarity");

  property p_bin_low;
    @(posedge sys_clk) disable iff (srst)
    (!s.extRange && !adcFault && wholeDeg < 0) |-> fmtHi == 8'h00;
  endproperty
  a_bin_low: assert property (p_bin_low)
    else $error("negative binary result not clamped to zero");

  property p_bin_high;
    @(posedge sys_clk) disable iff (srst)
    (!s.extRange && !adcFault && wholeDeg > BIN_MAX_DEG) |->
      fmtHi == BIN_HIGH_CLAMP;
  endproperty
  a_bin_high: assert property (p_bin_high)
    else $error("binary result above range not clamped");

  property p_ext_low;
    @(posedge sys_clk) disable iff (srst)
    (s.extRange && !adcFault && wholeDeg <= EXT_MIN_DEG) |->
      fmtHi == OFS_LOW_CLAMP;
  endproperty
  a_ext_low: assert property (p_ext_low)
    else $error("offset binary low saturation wrong");

endmodule // temp_scan_alarm_format

// ### design/temp_scan_pkg.sv
/*
  Shared constants and types of the temperature scan, alarm and result
  formatting block: register offsets, reset values, field positions,
  format codes and the sensor sequencing helper.
  Assumes a 32-bit APB slave with byte addresses on word boundaries.
*/
package temp_scan_pkg;

  localparam int NUM_SENSORS = 4;
  localparam int RAW_W       = 13;
  localparam int FRAC_W      = 3;
  localparam int DEG_W       = RAW_W - FRAC_W;
  localparam int DRIVE_W     = 14;

  // Register byte offsets
  localparam logic [7:0] OFS_SCAN       = 8'h00;
  localparam logic [7:0] OFS_THR_A      = 8'h04;
  localparam logic [7:0] OFS_THR_B      = 8'h08;
  localparam logic [7:0] OFS_ALM_CFG    = 8'h0C;
  localparam logic [7:0] OFS_HYST       = 8'h10;
  localparam logic [7:0] OFS_CTRL       = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_RESULT     = 8'h20;
  localparam logic [7:0] OFS_RESULT_END = 8'h3C;

  // Values after reset
  localparam logic [3:0] RST_SCAN    = 4'h1;
  localparam logic [7:0] RST_THR_A   = 8'h50;
  localparam logic [7:0] RST_THR_B   = 8'h00;
  localparam logic [7:0] RST_ALM_CFG = 8'h00;
  localparam logic [7:0] RST_HYST    = 8'h02;

  // Control word fields
  localparam int CTRL_EXT_BIT    = 0;
  localparam int CTRL_CONT_BIT   = 1;
  localparam int CTRL_START_BIT  = 2;
  localparam int CTRL_CANCEL_LSB = 3;

  // Alarm configuration: one nibble per alarm
  localparam int ALM_W         = 4;
  localparam int ALM_SRC_LSB   = 0;
  localparam int ALM_UNDER_BIT = 2;
  localparam int ALM_POL_BIT   = 3;

  // Result codes
  localparam logic [7:0] OFFSET_CODE    = 8'h40;
  localparam logic [7:0] OFS_LOW_CLAMP  = 8'h18;
  localparam logic [7:0] OFS_HIGH_CLAMP = 8'hCC;
  localparam logic [7:0] BIN_HIGH_CLAMP = 8'h7F;
  localparam logic [7:0] FAULT_CODE     = 8'hFF;
  localparam logic signed [DEG_W-1:0] EXT_MIN_DEG = -10'sd40;
  localparam logic signed [DEG_W-1:0] EXT_MAX_DEG = 10'sd140;
  localparam logic signed [DEG_W-1:0] BIN_MAX_DEG = 10'sd127;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_STORE} scan_state_t;
  typedef enum logic [1:0] {
    CANCEL_NONE, CANCEL_THREE_POINT, CANCEL_FOUR_WIRE
  } cancel_mode_t;

  // First enabled sensor after cur, wrapping; cur itself if alone
  function automatic logic [1:0] nextSensor(input logic [1:0] cur,
                                            input logic [3:0] mask);
    logic [1:0] idx;
    logic       found;
    nextSensor = cur;
    found      = 1'b0;
    for (int i = 1; i <= NUM_SENSORS; i++) begin
      idx = cur + 2'(i);
      if (mask[idx] && !found) begin
        nextSensor = idx;
        found      = 1'b1;
      end
    end
  endfunction

endpackage

// ### sim/adc_diode_model.sv
/*
  Far-side model: converter plus diodes, answering each adcStart
  after a random 1..8 cycles with that sensor's temperature.
  Assumes the bench sets temps and satLow per sensor index; satLow
  marks a diode fault, and the sign of temps picks the saturated rail.
*/
`timescale 1ns/1ps
module adc_diode_model (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic             adcStart,
  input  wire logic [1:0]       adcSel,
  input  wire logic [3:0][12:0] temps,
  input  wire logic [3:0]       satLow,
  output logic                  adcDone,
  output logic signed [12:0]    adcTemp,
  output logic                  adcSatLow,
  output logic                  adcSatHigh
);
  logic       busy = 1'b0;
  logic [2:0] waitCnt = 3'h0;
  logic [1:0] sel = 2'h0;
  initial begin
    adcDone = 1'b0;
    adcTemp = '0;
    adcSatLow = 1'b0;
    adcSatHigh = 1'b0;
  end
  always @(posedge sys_clk) begin
    adcDone <= 1'b0;
    // Not valid between results: keep it moving
    adcTemp <= ~adcTemp;
    adcSatLow <= ~adcSatLow;
    adcSatHigh <= ~adcSatHigh;
    if (srst) begin
      busy <= 1'b0;
    end else if (adcStart) begin
      busy <= 1'b1;
      waitCnt <= 3'($urandom_range(0, 7));
      sel <= adcSel;
    end else if (busy && waitCnt == 3'h0) begin
      busy <= 1'b0;
      adcDone <= 1'b1;
      adcTemp <= temps[sel];
      adcSatLow <= satLow[sel] && temps[sel][12];
      adcSatHigh <= satLow[sel] && !temps[sel][12];
    end else if (busy) begin
      waitCnt <= waitCnt - 3'h1;
    end
  end
endmodule // adc_diode_model

// ### sim/temp_scan_alarm_format_test.sv
/*
  Self-checking bench: APB master, scan, format and alarm model.
  Assumes the converter model answers every start it sees.
*/
`timescale 1ns/1ps
module temp_scan_alarm_format_test;
  import temp_scan_pkg::*;
  logic                    sys_clk, srst, psel, penable, pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    pready, pslverr, adcStart, adcDone, er;
  logic [1:0]              adcSel, sensePos, senseNeg, cancel;
  logic signed [RAW_W-1:0] adcTemp;
  logic                    adcSatLow, adcSatHigh, currentMatch;
  logic                    senseDiff, firstAlarmOutput, secondAlarmOutput;
  logic [3:0]              portExcite, portCancel, satLow;
  logic [3:0][12:0]        temps;
  logic [1:0]              selQ[$];
  logic [13:0]             drvQ[$];
  int                      bad_count, checked, thr1, thr2, hyst;
  bit                      ext, act1, act2, almOn;
  int raws[9] = '{-8, 0, 401, 1016, 1024, -320, -328, 1120, 1119};
  int ord[3] = '{0, 2, 3};

  temp_scan_alarm_format dut (.sys_clk(sys_clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .adcStart(adcStart), .adcSel(adcSel),
    .adcDone(adcDone), .adcTemp(adcTemp), .adcSatLow(adcSatLow),
    .adcSatHigh(adcSatHigh), .portExcite(portExcite),
    .portCancel(portCancel), .currentMatch(currentMatch),
    .senseDiff(senseDiff), .sensePos(sensePos), .senseNeg(senseNeg),
    .firstAlarmOutput(firstAlarmOutput),
    .secondAlarmOutput(secondAlarmOutput));
  adc_diode_model model (.sys_clk(sys_clk), .srst(srst),
    .adcStart(adcStart), .adcSel(adcSel), .temps(temps),
    .satLow(satLow), .adcDone(adcDone), .adcTemp(adcTemp),
    .adcSatLow(adcSatLow), .adcSatHigh(adcSatHigh));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (adcStart === 1'b1) begin
    selQ.push_back(adcSel);
    drvQ.push_back({portExcite, portCancel, currentMatch, senseDiff,
                    sensePos, senseNeg});
  end

  task chk(input string nm, input logic [31:0] seen,
           input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] fmt(int r, bit x);
    int d;
    d = r >>> 3;
    if (x) begin
      if (d <= -40) return 16'h1800;
      if (d >= 140) return 16'hCC00;
      return {8'(d + 64), 8'(r & 7)};
    end
    if (d < 0) return 16'h0000;
    if (d > 127) return 16'h7F00;
    return {8'(d), 8'(r & 7)};
  endfunction
  task waitIdle;
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 300);
    if (n >= 300) bad_count++;
  endtask
  task conv(input int r, input logic sl);
    logic [15:0] e;
    int c;
    temps[1] <= 13'(r);
    satLow[1] <= sl;
    apb(1'b1, OFS_CTRL, 32'(cancel * 8 + 4 + ext));
    waitIdle;
    e = sl ? 16'hFFFF : fmt(r, ext);
    c = e[15:8];
    // Reads both bytes before any new conversion
    apb(1'b0, OFS_RESULT + 8'h08, 32'h0);
    chk("hi byte", rd, e[15:8]);
    apb(1'b0, OFS_RESULT + 8'h0C, 32'h0);
    chk("lo byte", rd, e[7:0]);
    if (almOn) begin
      // A faulty reading leaves both alarms where they were
      if (!sl) begin
        act1 = act1 ? (c > thr1 - hyst) : (c > thr1);
        act2 = act2 ? (c < thr2 + hyst) : (c < thr2);
      end
      chk("alarm one", firstAlarmOutput, act1);
      chk("alarm two", secondAlarmOutput, !act2);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    end_of_test;
  end

  initial begin
    int n;
    static logic [7:0] ra[5] = '{OFS_SCAN, OFS_THR_A, OFS_THR_B,
                                 OFS_ALM_CFG, OFS_HYST};
    static logic [7:0] rv[5] = '{8'(RST_SCAN), RST_THR_A, RST_THR_B,
                                 RST_ALM_CFG, RST_HYST};
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    temps = '0;
    satLow = 4'h0;
    cancel = 2'h0;
    void'($urandom(32'h4EEE5A6B));
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    chk("alarm idle", firstAlarmOutput, 1'b1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h02, 32'h0);
    chk("unaligned err", er, 1'b1);
    $display("register test done");
    // Scan order and single pass
    temps[0] <= 13'd200;
    temps[2] <= -13'sd16;
    temps[3] <= 13'd1200;
    apb(1'b1, OFS_SCAN, 32'hD);
    apb(1'b1, OFS_CTRL, 32'h4);
    waitIdle;
    repeat (30) @(posedge sys_clk);
    chk("pass count", selQ.size(), 3);
    for (int i = 0; i < 3; i++) begin
      chk("order", selQ[i], ord[i]);
      apb(1'b0, OFS_RESULT + 8'(8 * ord[i]), 32'h0);
      chk("stored hi", rd, fmt(int'($signed(temps[ord[i]])), 0)
          >> 8);
    end
    selQ.delete();
    apb(1'b1, OFS_CTRL, 32'h2);
    n = 0;
    while (selQ.size() < 7 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    waitIdle;
    for (int i = 0; i < 6; i++) chk("loop order", selQ[i], ord[i % 3]);
    $display("scan test done");
    // Alarms on ext one: first over/high, second under/low
    apb(1'b1, OFS_SCAN, 32'h2);
    thr1 = 60;
    thr2 = 20;
    hyst = 3;
    apb(1'b1, OFS_THR_A, 32'(thr1));
    apb(1'b1, OFS_THR_B, 32'(thr2));
    apb(1'b1, OFS_HYST, 32'(hyst));
    apb(1'b1, OFS_ALM_CFG, 32'h59);
    almOn = 1;
    raws = '{400, 488, 464, 456, 448, 152, 168, 176, 184};
    foreach (raws[i]) conv(raws[i], 1'b0);
    conv(490, 1'b0);
    // A live compare against this threshold would drop the alarm
    thr1 = 255;
    apb(1'b1, OFS_THR_A, 32'(thr1));
    repeat (5) @(posedge sys_clk);
    chk("no early eval", firstAlarmOutput, act1);
    conv(8, 1'b0);
    $display("alarm test done");
    raws = '{-8, 0, 401, 1016, 1024, -320, -328, 1120, 1119};
    for (int x = 0; x < 2; x++) begin
      ext = x;
      foreach (raws[i]) conv(raws[i], 1'b0);
      repeat (4) conv(int'($urandom_range(0, 1600)) - 400, 1'b0);
    end
    conv(500, 1'b1);
    conv(-500, 1'b1);
    $display("format test done");
    cancel = 2'h1;
    conv(400, 1'b0);
    chk("three point", drvQ[$],
        {4'h1, 4'h2, 1'b1, 1'b1, 2'd0, 2'd1});
    cancel = 2'h2;
    conv(400, 1'b0);
    chk("four wire", {drvQ[$][13:10], drvQ[$][3:0]}, 8'hC1);
    $display("drive test done");
    end_of_test;
  end
endmodule // temp_scan_alarm_format_test
